//--- src/sdma_core.sv
/*
  Script DMA core registers and sequencer: AXI4-Lite slave, script fetch and
  decode, block-move bursts on the host bus, longitudinal parity.
  Assumes fetch port, host bus handshake and FIFO byte taps share i_clk.
*/
// What this block does
// - Parity register XORs every byte crossing FIFO and SCSI core, except a byte in a cycle that loads the ID.
// - A write to the parity register clears it to zero, or to a byte crossing that cycle; an ID load wins.
// - Selection/reselection ID is loaded into the parity register.
// - Byte count falls as data moves, in either direction.
// - Count falls once per address strobe, by bytes moved.
// - Byte count holds at most 16,777,215.
// - Zero-count block move raises illegal instruction, except target command phase.
// - Table-indirect I/O leaves the table offset in the count register.
// - Command register holds the current opcode byte.
// - Next data address is loaded from a block move's second longword.
// - Writing the script pointer runs scripts until an interrupt.
// - Single step halts after each instruction; start bit resumes.
// - Writing the pointer's top byte starts execution.
// - Pointer save takes each instruction's second longword.
// - Interrupt instruction leaves its vector in pointer save.
// - Scratch changes only by register writes targeting it.
// - Burst field selects 1, 2, 4 or 8 transfers.
// - Bus requested with room for a burst, or for alignment.
// - Cache bursts are four transfers when enabled and burst is 4 or 8.
// - A fairness gap of 5 to 8 clocks separates ownerships.
// - Function code bits drive pins while bus master.
// - Start bit fetches from the script pointer.
// - Manual bit clear: pointer write starts; set: wait for start bit.
`default_nettype none
module sdma_core (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // AXI4-Lite slave
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Script instruction fetch
  output logic             o_fetch_req,
  output logic [31:0]      o_fetch_addr,
  input  wire logic        i_fetch_valid,
  input  wire logic [31:0] i_fetch_w0,
  input  wire logic [31:0] i_fetch_w1,
  // Host bus mastership
  output logic             o_bus_req,
  input  wire logic        i_bus_grant,
  output logic             o_bus_own,
  output logic             o_addr_strobe,
  output logic [31:0]      o_bus_addr,
  output logic [1:0]       o_func_code,
  input  wire logic        i_xfer_ack,
  input  wire logic [2:0]  i_xfer_bytes,
  input  wire logic [5:0]  i_fifo_room,
  // SCSI core taps
  input  wire logic        i_fifo_byte_valid,
  input  wire logic [7:0]  i_fifo_byte,
  input  wire logic        i_sel_id_valid,
  input  wire logic [7:0]  i_sel_id,
  input  wire logic        i_target_cmd_phase,
  // Events
  output logic             o_step_event,
  output logic             o_illegal_event,
  output logic             o_int_event
);
  // Registers
  logic [7:0]  parity_q, cmd_q, scratch_q, mode_q, ctrl_q;
  logic [23:0] count_q;
  logic [31:0] nda_q, sp_q, sps_q;
  logic [3:0]  stat_q;
  sdma_pkg::sdma_state_t state_q;
  logic [3:0]  xfers_left_q;
  logic        wait_ack_q, strobe_q, fair_start;
  logic        fair_busy;

  // Bus slave handshakes
  logic wr_take, rd_take;
  assign wr_take   = i_awvalid && i_wvalid && !o_bvalid;
  assign rd_take   = i_arvalid && !o_rvalid;
  assign o_awready = wr_take;
  assign o_wready  = wr_take;
  assign o_arready = rd_take;

  function automatic logic wr_hit(input logic [7:0] ofs);
    return wr_take && (i_awaddr == ofs);
  endfunction

  logic wr_mapped;
  always_comb begin
    case (i_awaddr)
      sdma_pkg::OFS_PARITY, sdma_pkg::OFS_COUNT, sdma_pkg::OFS_CMD, sdma_pkg::OFS_NDA,
      sdma_pkg::OFS_SP, sdma_pkg::OFS_SPS, sdma_pkg::OFS_SCRATCH, sdma_pkg::OFS_MODE,
      sdma_pkg::OFS_CTRL, sdma_pkg::OFS_STAT: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= sdma_pkg::RESP_OKAY;
    end else if (wr_take) begin
      o_bvalid <= 1'b1;
      o_bresp  <= wr_mapped ? sdma_pkg::RESP_OKAY : sdma_pkg::RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
      o_rdata  <= sdma_pkg::RST_WORD;
      o_rresp  <= sdma_pkg::RESP_OKAY;
    end else if (rd_take) begin
      o_rvalid <= 1'b1;
      o_rresp  <= sdma_pkg::RESP_OKAY;
      case (i_araddr)
        sdma_pkg::OFS_PARITY:  o_rdata <= {24'h000000, parity_q};
        sdma_pkg::OFS_COUNT:   o_rdata <= {8'h00, count_q};
        sdma_pkg::OFS_CMD:     o_rdata <= {24'h000000, cmd_q};
        sdma_pkg::OFS_NDA:     o_rdata <= nda_q;
        sdma_pkg::OFS_SP:      o_rdata <= sp_q;
        sdma_pkg::OFS_SPS:     o_rdata <= sps_q;
        sdma_pkg::OFS_SCRATCH: o_rdata <= {24'h000000, scratch_q};
        sdma_pkg::OFS_MODE:    o_rdata <= {24'h000000, mode_q};
        sdma_pkg::OFS_CTRL:    o_rdata <= {24'h000000, ctrl_q};
        sdma_pkg::OFS_STAT:    o_rdata <= {28'h0000000, stat_q};
        default: begin
          o_rdata <= sdma_pkg::RST_WORD;
          o_rresp <= sdma_pkg::RESP_SLVERR;
        end
      endcase
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // Longitudinal parity: ID load, then clear, then accumulate
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      parity_q <= sdma_pkg::RST_BYTE;
    end else if (i_sel_id_valid) begin
      parity_q <= i_sel_id;
    end else if (wr_hit(sdma_pkg::OFS_PARITY)) begin
      parity_q <= i_fifo_byte_valid ? i_fifo_byte : sdma_pkg::RST_BYTE;
    end else if (i_fifo_byte_valid) begin
      parity_q <= parity_q ^ i_fifo_byte;
    end
  end

  // Decode of a fetched instruction
  logic [1:0] f_type;
  logic [2:0] f_op;
  logic       f_block, f_int, f_rw, f_zero_ill;
  assign f_type     = i_fetch_w0[31:30];
  assign f_op       = i_fetch_w0[29:27];
  assign f_block    = (f_type == sdma_pkg::ITYPE_BLOCK);
  assign f_int      = (f_type == sdma_pkg::ITYPE_XFER) && (f_op == sdma_pkg::OP_INT);
  assign f_rw       = (f_type == sdma_pkg::ITYPE_IO) && (f_op == sdma_pkg::OP_RWREG);
  assign f_zero_ill = f_block && (i_fetch_w0[23:0] == 24'h000000)
                      && !i_target_cmd_phase;
  logic fetched;
  assign fetched = (state_q == sdma_pkg::ST_FETCH) && i_fetch_valid;

  // Burst sizing
  logic [1:0] bl;
  logic [3:0] burst_xfers;
  logic [5:0] burst_bytes;
  assign bl = mode_q[sdma_pkg::MODE_BURST_LSB +: 2];
  always_comb begin
    if (ctrl_q[sdma_pkg::CTRL_CACHE] && bl[1]) begin
      burst_xfers = sdma_pkg::CACHE_XFERS;
    end else begin
      burst_xfers = 4'(4'h1 << bl);
    end
  end
  assign burst_bytes = {burst_xfers, 2'b00};

  logic want_bus;
  assign want_bus = (i_fifo_room >= burst_bytes) ||
                    (count_q < {18'h00000, burst_bytes});

  // Bytes moved by the acknowledged transfer, never past zero
  logic [23:0] moved;
  assign moved = ({21'h000000, i_xfer_bytes} > count_q) ? count_q
                                                       : {21'h000000, i_xfer_bytes};
  logic acked;
  assign acked = (state_q == sdma_pkg::ST_XFER) && wait_ack_q && i_xfer_ack;

  // Start conditions
  localparam logic [23:0] RST0 = sdma_pkg::RST_CNT;
  logic sp_top_write, std_write, start_req, instr_done, halt_now;
  assign sp_top_write = wr_hit(sdma_pkg::OFS_SP) && i_wstrb[3];
  assign std_write    = wr_hit(sdma_pkg::OFS_CTRL) && i_wdata[sdma_pkg::CTRL_STD];
  assign start_req    = (sp_top_write && !mode_q[sdma_pkg::MODE_MANUAL]) || std_write;
  assign instr_done   = (fetched && !f_block && !f_int) ||
                        ((state_q == sdma_pkg::ST_FAIR) && !fair_busy && count_q == RST0);
  assign halt_now     = ctrl_q[sdma_pkg::CTRL_SSM];

  // Sequencer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= sdma_pkg::ST_IDLE;
    end else begin
      case (state_q)
        sdma_pkg::ST_IDLE: begin
          if (start_req) state_q <= sdma_pkg::ST_FETCH;
        end
        sdma_pkg::ST_FETCH: begin
          if (fetched) begin
            if (f_int || f_zero_ill) begin
              state_q <= sdma_pkg::ST_IDLE;
            end else if (f_block) begin
              state_q <= sdma_pkg::ST_ARB;
            end else if (halt_now) begin
              state_q <= sdma_pkg::ST_IDLE;
            end
          end
        end
        sdma_pkg::ST_ARB: begin
          if (i_bus_grant && o_bus_req) state_q <= sdma_pkg::ST_XFER;
        end
        sdma_pkg::ST_XFER: begin
          if (acked && (xfers_left_q == 4'h1 || count_q == moved)) begin
            state_q <= sdma_pkg::ST_FAIR;
          end
        end
        sdma_pkg::ST_FAIR: begin
          if (!fair_busy) begin
            if (count_q != RST0) begin
              state_q <= sdma_pkg::ST_ARB;
            end else if (halt_now) begin
              state_q <= sdma_pkg::ST_IDLE;
            end else begin
              state_q <= sdma_pkg::ST_FETCH;
            end
          end
        end
        default: state_q <= sdma_pkg::ST_IDLE;
      endcase
    end
  end

  // Burst transfer tracking
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      xfers_left_q <= 4'h0;
      wait_ack_q   <= 1'b0;
      strobe_q     <= 1'b0;
    end else begin
      strobe_q <= 1'b0;
      if (state_q == sdma_pkg::ST_ARB && i_bus_grant && o_bus_req) begin
        xfers_left_q <= burst_xfers;
      end else if (state_q == sdma_pkg::ST_XFER) begin
        if (!wait_ack_q && !strobe_q) begin
          strobe_q   <= 1'b1;
          wait_ack_q <= 1'b1;
        end else if (acked) begin
          wait_ack_q   <= 1'b0;
          xfers_left_q <= xfers_left_q - 4'h1;
        end
      end
    end
  end
  assign fair_start = acked && (xfers_left_q == 4'h1 || count_q == moved);

  sdma_fair_gap #(
    .CYCLES (sdma_pkg::FAIR_CYCLES)
  ) u_fair (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_start (fair_start),
    .o_busy  (fair_busy)
  );

  // Byte counter, command, pointers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count_q <= sdma_pkg::RST_CNT;
      cmd_q   <= sdma_pkg::RST_BYTE;
    end else if (fetched) begin
      cmd_q   <= i_fetch_w0[31:24];
      count_q <= i_fetch_w0[23:0];
    end else if (acked) begin
      count_q <= count_q - moved;
    end else begin
      if (wr_hit(sdma_pkg::OFS_COUNT)) count_q <= i_wdata[23:0];
      if (wr_hit(sdma_pkg::OFS_CMD)) cmd_q <= i_wdata[7:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sps_q <= sdma_pkg::RST_WORD;
    end else if (fetched) begin
      sps_q <= i_fetch_w1;
    end else if (wr_hit(sdma_pkg::OFS_SPS)) begin
      sps_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      nda_q <= sdma_pkg::RST_WORD;
    end else if (fetched && f_block) begin
      nda_q <= i_fetch_w1;
    end else if (acked) begin
      nda_q <= nda_q + {29'h00000000, i_xfer_bytes};
    end else if (wr_hit(sdma_pkg::OFS_NDA)) begin
      nda_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sp_q <= sdma_pkg::RST_WORD;
    end else if (fetched) begin
      sp_q <= sp_q + sdma_pkg::INSTR_BYTES;
    end else if (wr_hit(sdma_pkg::OFS_SP)) begin
      for (int b = 0; b < 4; b++) begin
        if (i_wstrb[b]) sp_q[8*b +: 8] <= i_wdata[8*b +: 8];
      end
    end
  end

  // Scratch: software or a register-write instruction aimed at it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scratch_q <= sdma_pkg::RST_BYTE;
    end else if (fetched && f_rw && i_fetch_w0[23:16] == sdma_pkg::OFS_SCRATCH) begin
      scratch_q <= i_fetch_w0[15:8];
    end else if (wr_hit(sdma_pkg::OFS_SCRATCH)) begin
      scratch_q <= i_wdata[7:0];
    end
  end

  // Mode and control; start bit self-clears when taken
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_q <= sdma_pkg::RST_BYTE;
      ctrl_q <= sdma_pkg::RST_BYTE;
    end else begin
      if (wr_hit(sdma_pkg::OFS_MODE)) mode_q <= i_wdata[7:0];
      if (wr_hit(sdma_pkg::OFS_CTRL)) begin
        ctrl_q <= i_wdata[7:0];
        ctrl_q[sdma_pkg::CTRL_STD] <= 1'b0;
      end
    end
  end

  // Run bit follows the sequencer; other status bits sticky, write one to clear, setting wins
  logic step_set, ill_set, int_set;
  assign step_set = instr_done && halt_now;
  assign ill_set  = fetched && f_zero_ill;
  assign int_set  = fetched && f_int;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stat_q <= 4'h0;
    end else begin
      if (wr_hit(sdma_pkg::OFS_STAT)) stat_q <= stat_q & ~i_wdata[3:0];
      stat_q[sdma_pkg::STAT_RUN] <= (state_q != sdma_pkg::ST_IDLE);
      if (step_set) stat_q[sdma_pkg::STAT_STEP] <= 1'b1;
      if (ill_set) stat_q[sdma_pkg::STAT_ILL] <= 1'b1;
      if (int_set) stat_q[sdma_pkg::STAT_SINT] <= 1'b1;
    end
  end

  // Outputs
  assign o_fetch_req     = (state_q == sdma_pkg::ST_FETCH);
  assign o_fetch_addr    = sp_q;
  assign o_bus_req       = (state_q == sdma_pkg::ST_ARB) && want_bus;
  assign o_bus_own       = (state_q == sdma_pkg::ST_XFER);
  assign o_addr_strobe   = strobe_q;
  assign o_bus_addr      = nda_q;
  assign o_func_code     = o_bus_own ? mode_q[sdma_pkg::MODE_FC_LSB +: 2] : 2'b00;
  assign o_step_event    = step_set;
  assign o_illegal_event = ill_set;
  assign o_int_event     = int_set;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_last_ack;
    acked && (xfers_left_q == 4'h1 || count_q == moved);
  endsequence
  sequence s_gap;
    (state_q == sdma_pkg::ST_FAIR) [*5];
  endsequence

  a_parity_clear: assert property (wr_hit(sdma_pkg::OFS_PARITY) && !i_sel_id_valid
    && !i_fifo_byte_valid |=> parity_q == 8'h00) else $error("parity not cleared");
  a_parity_accum: assert property (i_fifo_byte_valid && !i_sel_id_valid
    && !wr_hit(sdma_pkg::OFS_PARITY) |=> parity_q == ($past(parity_q) ^ $past(i_fifo_byte)))
    else $error("parity not accumulated");
  a_sel_id: assert property (i_sel_id_valid |=> parity_q == $past(i_sel_id))
    else $error("selection id not loaded");
  a_count_dec: assert property (acked |=> count_q == $past(count_q) - $past(moved))
    else $error("byte count wrong after ack");
  a_zero_illegal: assert property (fetched && f_block && i_fetch_w0[23:0] == 24'h000000
    && !i_target_cmd_phase |=> stat_q[sdma_pkg::STAT_ILL] && state_q == sdma_pkg::ST_IDLE)
    else $error("zero count not illegal");
  a_fair_gap: assert property (s_last_ack |=> s_gap ##1 !o_bus_own)
    else $error("fairness gap too short");
  a_fc_drive: assert property (o_bus_own |-> o_func_code == mode_q[5:4])
    else $error("function code not driven");
  a_msb_start: assert property (state_q == sdma_pkg::ST_IDLE && sp_top_write
    && !mode_q[sdma_pkg::MODE_MANUAL] |=> state_q == sdma_pkg::ST_FETCH)
    else $error("pointer write did not start");
  a_scratch_keep: assert property (!wr_hit(sdma_pkg::OFS_SCRATCH) && !(fetched && f_rw)
    |=> $stable(scratch_q)) else $error("scratch changed");
  a_sps_load: assert property (fetched |=> sps_q == $past(i_fetch_w1))
    else $error("pointer save not loaded");
endmodule
`default_nettype wire

//--- src/sdma_pkg.sv
/*
  Constants shared by the script DMA core: register offsets, field positions,
  reset values, instruction decode fields and the controller state type.
  Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
*/
`default_nettype none
package sdma_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_PARITY  = 8'h00;
  localparam logic [7:0] OFS_COUNT   = 8'h04;
  localparam logic [7:0] OFS_CMD     = 8'h08;
  localparam logic [7:0] OFS_NDA     = 8'h0c;
  localparam logic [7:0] OFS_SP      = 8'h10;
  localparam logic [7:0] OFS_SPS     = 8'h14;
  localparam logic [7:0] OFS_SCRATCH = 8'h18;
  localparam logic [7:0] OFS_MODE    = 8'h1c;
  localparam logic [7:0] OFS_CTRL    = 8'h20;
  localparam logic [7:0] OFS_STAT    = 8'h24;
  // Transfer mode fields
  localparam int MODE_BURST_LSB = 6;
  localparam int MODE_FC_LSB    = 4;
  localparam int MODE_MANUAL    = 0;
  // Control fields
  localparam int CTRL_SSM   = 4;
  localparam int CTRL_STD   = 2;
  localparam int CTRL_CACHE = 0;
  // Status fields
  localparam int STAT_RUN  = 0;
  localparam int STAT_STEP = 1;
  localparam int STAT_ILL  = 2;
  localparam int STAT_SINT = 3;
  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [23:0] RST_CNT  = 24'h000000;
  localparam logic [31:0] RST_WORD = 32'h00000000;
  // Timing and burst figures
  localparam int          FAIR_CYCLES = 6;
  localparam logic [3:0]  CACHE_XFERS = 4'h4;
  localparam logic [31:0] INSTR_BYTES = 32'h00000008;
  // Instruction decode: word0[31:30] type, word0[29:27] opcode
  localparam logic [1:0] ITYPE_BLOCK = 2'h0;
  localparam logic [1:0] ITYPE_IO    = 2'h1;
  localparam logic [1:0] ITYPE_XFER  = 2'h2;
  localparam logic [2:0] OP_INT      = 3'h3;
  localparam logic [2:0] OP_RWREG    = 3'h7;
  localparam int         TI_BIT      = 25;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_FETCH = 3'h1,
    ST_ARB   = 3'h3,
    ST_XFER  = 3'h2,
    ST_FAIR  = 3'h6
  } sdma_state_t;
endpackage
`default_nettype wire

//--- src/sdma_fair_gap.sv
/*
  Fairness gap timer: after a start pulse, busy stays high for CYCLES clocks.
  Assumes start is a one-cycle pulse on the same clock.
*/
`default_nettype none
module sdma_fair_gap #(
  parameter int CYCLES = 6
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Control
  input  wire logic i_start,
  output logic      o_busy
);
  // Counter is eight bits wide
  if (CYCLES < 1 || CYCLES > 255) begin : g_bad_cycles
    $error("CYCLES out of range");
  end

  logic [7:0] cnt_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= 8'h00;
    end else if (i_start) begin
      cnt_q <= 8'(CYCLES);
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  assign o_busy = (cnt_q != 8'h00);
endmodule
`default_nettype wire

//--- bench/sdma_host_model.sv
/*
  Host side partner: script memory answering fetches, bus grant and
  transfer acknowledge, prompt or slow.
  Assumes the core's fetch and host bus handshake on the same clock.
*/
`default_nettype none
module sdma_host_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_slow,
  // Script fetch
  input  wire logic        i_fetch_req,
  input  wire logic [31:0] i_fetch_addr,
  output logic             o_fetch_valid,
  output logic [31:0]      o_w0,
  output logic [31:0]      o_w1,
  // Host bus
  input  wire logic        i_bus_req,
  output logic             o_grant,
  input  wire logic        i_strobe,
  output logic             o_ack,
  output logic [2:0]       o_bytes
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] prog [0:15];
  logic [63:0] w_q;
  logic [2:0]  fw_q;
  logic [2:0]  aw_q;
  logic        pend_q;
  // Words invert while not valid so stale data never looks valid
  assign o_w0    = o_fetch_valid ? w_q[63:32] : ~w_q[63:32];
  assign o_w1    = o_fetch_valid ? w_q[31:0] : ~w_q[31:0];
  assign o_grant = i_bus_req;
  assign o_bytes = o_ack ? 3'h4 : 3'h3;
  always_ff @(posedge i_clk) begin
    o_fetch_valid <= 1'b0;
    o_ack <= 1'b0;
    if (i_rst) begin
      fw_q <= 3'h0;
      pend_q <= 1'b0;
    end else begin
      if (i_fetch_req && !o_fetch_valid) begin
        if (fw_q == (i_slow ? 3'h3 : 3'h0)) begin
          o_fetch_valid <= 1'b1;
          w_q <= prog[i_fetch_addr[6:3]];
          fw_q <= 3'h0;
        end else fw_q <= fw_q + 3'h1;
      end
      if (i_strobe) begin
        pend_q <= 1'b1;
        aw_q <= 3'h0;
      end else if (pend_q) begin
        if (aw_q == (i_slow ? 3'h2 : 3'h0)) begin
          o_ack <= 1'b1;
          pend_q <= 1'b0;
        end else aw_q <= aw_q + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/sdma_core_bench.sv
/*
  Self-checking bench for the script DMA core over AXI4-Lite.
  Assumes the host model answers fetch and bus transfers.
*/
`default_nettype none
module sdma_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, awv, wv, bre, arv, rre, fbv, sv, tcp, slow, ownp;
  logic [7:0] awa, ara, fb, sid, sc;
  logic [31:0] wd, q, ms;
  logic [3:0] ws;
  logic [1:0] qr, fcx;
  logic [5:0] room;
  logic [2:0] ev;
  logic [15:0] r;
  int comparisons, n_mismatch, cyc, gap, nown, nstb, ngap, nfc, i, k, xf;
  wire awr, wrd, bv, arr, rv, freq, fv, breq, gnt, own, stb, ack, es, ei, en;
  wire [1:0] br, rr, fc;
  wire [31:0] rdat, fa, w0, w1, ba;
  wire [2:0] xb;
  logic [7:0] oa [6] = '{sdma_pkg::OFS_COUNT, sdma_pkg::OFS_CMD, sdma_pkg::OFS_NDA,
                         sdma_pkg::OFS_SPS, sdma_pkg::OFS_SCRATCH, sdma_pkg::OFS_MODE};
  logic [31:0] mk [6] = '{32'hffffff, 32'hff, 32'hffffffff, 32'hffffffff, 32'hff, 32'hff};
  sdma_core DUT (.i_clk(clk), .i_rst(rst), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr),
    .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv), .o_wready(wrd), .o_bresp(br), .o_bvalid(bv),
    .i_bready(bre), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdat),
    .o_rresp(rr), .o_rvalid(rv), .i_rready(rre), .o_fetch_req(freq), .o_fetch_addr(fa),
    .i_fetch_valid(fv), .i_fetch_w0(w0), .i_fetch_w1(w1), .o_bus_req(breq), .i_bus_grant(gnt),
    .o_bus_own(own), .o_addr_strobe(stb), .o_bus_addr(ba), .o_func_code(fc), .i_xfer_ack(ack),
    .i_xfer_bytes(xb), .i_fifo_room(room), .i_fifo_byte_valid(fbv), .i_fifo_byte(fb),
    .i_sel_id_valid(sv), .i_sel_id(sid), .i_target_cmd_phase(tcp), .o_step_event(es),
    .o_illegal_event(ei), .o_int_event(en));
  sdma_host_model host (.i_clk(clk), .i_rst(rst), .i_slow(slow), .i_fetch_req(freq),
    .i_fetch_addr(fa), .o_fetch_valid(fv), .o_w0(w0), .o_w1(w1), .i_bus_req(breq),
    .o_grant(gnt), .i_strobe(stb), .o_ack(ack), .o_bytes(xb));
  function automatic logic [15:0] lf(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    awa <= a; wd <= d; ws <= s; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    do @(posedge clk); while (awr !== 1'b1);
    awv <= 1'b0; wv <= 1'b0;
    while (bv !== 1'b1) @(posedge clk);
    qr = br;
    bre <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    q = rdat; qr = rr; rre <= 1'b0;
  endtask
  // Wait for a stop event, note which, clear status
  task automatic wt;
    do @(posedge clk); while ({es, ei, en} === 3'b000);
    ev = {es, ei, en};
    rd(sdma_pkg::OFS_STAT);
    chk("status", {ev[0], ev[1], ev[2], 1'b0}, q);
    wr(sdma_pkg::OFS_STAT, 32'he, 4'hf);
  endtask
  task final_report;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    ownp <= own;
    gap <= own ? 0 : gap + 1;
    if (own && !ownp) begin
      if (nown > 0 && (gap < 5 || gap > 8)) ngap++;
      nown++;
    end
    if (stb && k < 5) chk("bus addr", 32'h1000 + 4 * nstb, ba);
    if (stb) nstb++;
    if (own && fc !== fcx) nfc++;
    if (cyc == 40000) begin
      n_mismatch++;
      final_report;
    end
  end
  initial begin
    {rst, awv, wv, bre, arv, rre, fbv, sv, tcp, slow} = 10'h200;
    {awa, ara, fb, sid, wd, ws, fcx} = '0;
    room = 6'h3f; r = 16'hc15b;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) begin
      r = lf(r); ms = {lf(r), r} & 32'hfffffffe;
      wr(oa[i], ms, 4'hf); chk("write resp", sdma_pkg::RESP_OKAY, qr);
      rd(oa[i]); chk("register", ms & mk[i], q);
    end
    rd(8'h28); chk("unmapped", 32'h0, q); chk("read resp", sdma_pkg::RESP_SLVERR, qr);
    wr(8'h28, ms, 4'hf); chk("write err", sdma_pkg::RESP_SLVERR, qr);
    $display("test 1 done");
    wr(sdma_pkg::OFS_PARITY, {r, r}, 4'hf); sc = 8'h00;
    for (i = 0; i < 20; i++) begin
      r = lf(r); sc ^= r[7:0];
      @(posedge clk); fbv <= 1'b1; fb <= r[7:0];
    end
    @(posedge clk); fbv <= 1'b0;
    rd(sdma_pkg::OFS_PARITY); chk("parity", sc, q);
    wr(sdma_pkg::OFS_PARITY, 32'hff, 4'hf); rd(sdma_pkg::OFS_PARITY); chk("clear", 0, q);
    @(posedge clk); sv <= 1'b1; sid <= r[15:8];
    @(posedge clk); sv <= 1'b0;
    rd(sdma_pkg::OFS_PARITY); chk("sel id", r[15:8], q);
    $display("test 2 done");
    for (k = 0; k < 5; k++) begin
      r = lf(r); fcx <= r[1:0]; sc = r[15:8]; slow <= r[2]; xf = k == 4 ? 4 : 1 << k;
      host.prog[0] = {8'h78, 8'h18, sc, 40'h0};
      host.prog[1] = 64'h00000024_00001000;
      host.prog[2] = 64'h98000000_000000a5;
      wr(sdma_pkg::OFS_MODE, {k == 4 ? 2'h3 : k[1:0], r[1:0], 4'h0}, 4'hf);
      wr(sdma_pkg::OFS_CTRL, k == 4, 4'hf);
      {nown, nstb, ngap, nfc} = '0;
      wr(sdma_pkg::OFS_SP, 32'h0, 4'hf); wt;
      chk("event", 3'b001, ev);
      chk("ownerships", (9 + xf - 1) / xf, nown);
      chk("strobes", 9, nstb);
      chk("gap", 0, ngap);
      chk("func code", 0, nfc);
      rd(sdma_pkg::OFS_COUNT); chk("count", 0, q);
      rd(sdma_pkg::OFS_NDA); chk("nda", 32'h1024, q);
      rd(sdma_pkg::OFS_SCRATCH); chk("scratch", sc, q);
      rd(sdma_pkg::OFS_SPS); chk("vector", 32'ha5, q);
      rd(sdma_pkg::OFS_CMD); chk("command", 8'h98, q);
      rd(sdma_pkg::OFS_SP); chk("pointer", 32'h18, q);
    end
    $display("test 3 done");
    host.prog[4] = 64'h0; host.prog[5] = 64'h98000000_000000a5;
    wr(sdma_pkg::OFS_SP, 32'h20, 4'hf); wt; chk("zero count", 3'b010, ev);
    // No FIFO room: only the alignment clause can request the bus
    tcp <= 1'b1; room <= 6'h00;
    wr(sdma_pkg::OFS_SP, 32'h20, 4'hf); wt; chk("target cmd", 3'b001, ev);
    tcp <= 1'b0; room <= 6'h3f;
    $display("test 4 done");
    wr(sdma_pkg::OFS_MODE, 32'h1, 4'hf); wr(sdma_pkg::OFS_CTRL, 32'h10, 4'hf);
    wr(sdma_pkg::OFS_SP, 32'h0, 4'hf);
    repeat (6) @(posedge clk);
    chk("manual hold", 0, freq);
    for (i = 1; i < 3; i++) begin
      wr(sdma_pkg::OFS_CTRL, 32'h14, 4'hf); wt; chk("step", 3'b100, ev);
      rd(sdma_pkg::OFS_SP); chk("step ptr", 8 * i, q);
    end
    $display("test 5 done");
    wr(sdma_pkg::OFS_MODE, 32'h0, 4'hf); wr(sdma_pkg::OFS_CTRL, 32'h0, 4'hf);
    wr(sdma_pkg::OFS_SP, 32'h10, 4'h7);
    repeat (6) @(posedge clk);
    chk("low bytes", 0, freq);
    wr(sdma_pkg::OFS_SP, 32'h0, 4'h8); wt; chk("top byte", 3'b001, ev);
    $display("test 6 done");
    final_report;
  end
endmodule
`default_nettype wire
